// ### pflc_params.svh
// Purpose: Constants for the power-fail lock-out control block.
// Assumes: 40 MHz clock and a 1 us internal timebase tick.
// Notes:   Included by every design file of the block.
`ifndef PFLC_PARAMS_SVH
`define PFLC_PARAMS_SVH

`define PFLC_ADDR_W          5
`define PFLC_DATA_W          8
`define PFLC_SAVE_W          32

// Timebase.
`define PFLC_CLK_PERIOD_NS   25
`define PFLC_TICK_NS         1000
`define PFLC_TICK_CYCLES     (`PFLC_TICK_NS / `PFLC_CLK_PERIOD_NS)
`define PFLC_DIV_W           6

// Intervals as printed, then in ticks.
`define PFLC_DEB_MIN_US      30
`define PFLC_DEB_MAX_US      63
`define PFLC_DELAY_US        480
`define PFLC_STROBE_US       30
`define PFLC_DEB_TICKS       (((`PFLC_DEB_MIN_US * 1000 + `PFLC_TICK_NS - 1) / `PFLC_TICK_NS) + 2)
`define PFLC_DELAY_TICKS     ((`PFLC_DELAY_US * 1000) / `PFLC_TICK_NS)
`define PFLC_STROBE_TICKS    (((`PFLC_STROBE_US * 1000 + `PFLC_TICK_NS - 1) / `PFLC_TICK_NS) + 1)
`define PFLC_CNT_W           10

// Register offsets.
`define PFLC_OFS_MAIN_STATUS 5'h00
`define PFLC_OFS_RT_MODE     5'h01
`define PFLC_OFS_PERIODIC    5'h03
`define PFLC_OFS_ROUTING     5'h04
`define PFLC_OFS_INT_CTRL0   5'h03
`define PFLC_OFS_INT_CTRL1   5'h04

// Field positions.
`define PFLC_MSR_IRQ_BIT     0
`define PFLC_MSR_PF_BIT      1
`define PFLC_MSR_LOWBAT_BIT  6
`define PFLC_MSR_RSEL_BIT    7
`define PFLC_RTM_START_BIT   3
`define PFLC_RTM_TMR_PF_BIT  6
`define PFLC_RTM_INT_PF_BIT  7
`define PFLC_PFR_OSC_BIT     6
`define PFLC_RTE_ROUTE_BIT   0
`define PFLC_RTE_DELAY_BIT   3
`define PFLC_IC0_TSE_BIT     7
`define PFLC_IC1_PFIE_BIT    7

`define PFLC_DATA_ZERO       8'h00

`endif

// ### pflc_pkg.sv
// Purpose: Types shared by the power-fail lock-out control block.
// Assumes: Nothing beyond the constants header.
// Notes:   Pins travel as packed out/enable pairs.
`default_nettype none
`include "pflc_params.svh"
package pflc_pkg;

  typedef struct packed {
    logic value;
    logic oe;
  } pflc_pin_t;

  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic [`PFLC_ADDR_W-1:0] addr;
    logic [`PFLC_DATA_W-1:0] data;
  } pflc_bus_t;

  typedef enum logic [1:0] {
    PFLC_RUN    = 2'b00,
    PFLC_DELAY  = 2'b01,
    PFLC_LOCKED = 2'b10
  } pflc_lock_t;

endpackage
`default_nettype wire

// ### pflc_debounce.sv
// Purpose: Two-way debounce of a synchronised level on the timebase tick.
// Assumes: tick is a one-cycle pulse every microsecond.
// Notes:   The level must stay changed for a full run of ticks to flip.
`timescale 1ns/1ps
`default_nettype none
`include "pflc_params.svh"
module pflc_debounce (
  // Clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // Control
  input  wire logic tick,
  input  wire logic enable,
  input  wire logic level_in,
  // Result
  output logic      level_out
);
  import pflc_pkg::*;

  logic [`PFLC_CNT_W-1:0] count;

  // A disabled sensor holds its last verdict and restarts from zero.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      count     <= '0;
      level_out <= 1'b0;
    end else if (!enable || level_in == level_out) begin
      count <= '0;
    end else if (tick) begin
      if (count == `PFLC_CNT_W'(`PFLC_DEB_TICKS - 1)) begin
        level_out <= level_in;
        count     <= '0;
      end else begin
        count <= count + `PFLC_CNT_W'(1);
      end
    end
  end

endmodule
`default_nettype wire

// ### pflc_interval.sv
// Purpose: Interval timer counting timebase ticks while run is high.
// Assumes: tick is a one-cycle pulse every microsecond.
// Notes:   done stays high until run drops; dropping run clears it.
`timescale 1ns/1ps
`default_nettype none
`include "pflc_params.svh"
module pflc_interval #(
  parameter int LIMIT = 1
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // Control
  input  wire logic tick,
  input  wire logic run,
  // Result
  output logic      done
);
  import pflc_pkg::*;

  logic [`PFLC_CNT_W-1:0] count;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      count <= '0;
      done  <= 1'b0;
    end else if (!run) begin
      count <= '0;
      done  <= 1'b0;
    end else if (tick && !done) begin
      if (count == `PFLC_CNT_W'(LIMIT - 1)) begin
        done <= 1'b1;
      end
      count <= count + `PFLC_CNT_W'(1);
    end
  end

endmodule
`default_nettype wire

// ### pflc_top.sv
// Purpose: Power-failure supervision, bus lock-out and pin isolation.
// Assumes: Bus and pin inputs are asynchronous; standby and battery
//          comparator results arrive already on this clock.
// Notes:   Timer and clock counter logic live outside this block.
//
// Function
// (R1) Power-fail input low counts only after a 30 to 63 us debounce.
// (R2) Debounce expiry raises the internal power-failing signal and interrupt.
// (R3) Without lock-out delay, bus disconnects within 30 to 63 us.
// (R4) With lock-out delay set, bus stays usable 480 us, then locks.
// (R5) Host clearing the delay bit forces lock-out at once.
// (R6) Strobe held over 30 us after failure with chip select forces lock.
// (R7) Locked: bus ignored; gates live until standby; outputs open drain (the block makes them open drain only in standby).
// (R8) Timer and interrupt power-fail bits choose run or stop after failure.
// (R9) Stay locked while input low; unlock after a second debounce.
// (R10) Interrupt enable low still locks out but gives no interrupt.
// (R11) Interrupt enable low also freezes the low-battery status.
// (R12) Low-battery set only on main supply with battery below about 2.1V.
// (R13) Initial power-up sets oscillator-fail flag and clears clock start.
// (R14) Oscillator-fail flag holds until software starts the clock.
// (R15) Host writes periodic bit D6 low for battery mode; flag unaffected.
// (R16) Time-save enable copies the running counters continuously.
// (R17) Switching to battery clears time-save enable; software may clear.
// (R18) Standby follows the supply comparator, independent of power-fail.
// (R19) Power-fail sensing is switched off in battery standby.
// (R20) Single-supply use: software sets single-supply bit, disables interrupt.
// (R21) Power-fail status mirrors the internal signal; only power clears it.
// (R22) Route bit sends the power-fail interrupt to irq or multifunction.
// (R23) Standby is a synchronous input; intervals come from a fixed tick.
`timescale 1ns/1ps
`default_nettype none
`include "pflc_params.svh"
module pflc_top (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     sys_rst,
  // Host parallel bus pins, strobes active low
  input  wire logic                     chip_sel_n,
  input  wire logic                     read_n,
  input  wire logic                     write_n,
  input  wire logic [`PFLC_ADDR_W-1:0]  addr,
  input  wire logic [`PFLC_DATA_W-1:0]  data_in,
  output logic      [`PFLC_DATA_W-1:0]  data_out,
  output logic                          data_oe,
  // Power supervision
  input  wire logic                     power_fail_in_n,
  input  wire logic                     standby,
  input  wire logic                     battery_low,
  // Timer pins and levels
  input  wire logic                     gate_in_zero,
  input  wire logic                     gate_in_one,
  input  wire logic                     timer_clock_in,
  input  wire logic                     timer_one_level,
  input  wire logic                     multifunction_level,
  output logic                          gate_zero_live,
  output logic                          gate_one_live,
  output logic                          timer_clock_live,
  output pflc_pkg::pflc_pin_t           irq_out,
  output pflc_pkg::pflc_pin_t           multifunction_out,
  output pflc_pkg::pflc_pin_t           timer_one_out,
  // Run permissions and time save
  input  wire logic [`PFLC_SAVE_W-1:0]  clock_count,
  output logic      [`PFLC_SAVE_W-1:0]  saved_time,
  output logic                          timers_run,
  output logic                          interrupts_run,
  output logic                          clock_start,
  output logic                          bus_locked
);
  import pflc_pkg::*;

  // Timebase divider.
  logic [`PFLC_DIV_W-1:0] div_count;
  logic                   tick;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      div_count <= '0;
      tick      <= 1'b0;
    end else if (div_count == `PFLC_DIV_W'(`PFLC_TICK_CYCLES - 1)) begin
      div_count <= '0;
      tick      <= 1'b1; // R23
    end else begin
      div_count <= div_count + `PFLC_DIV_W'(1);
      tick      <= 1'b0;
    end
  end

  // Two-flop synchronisers for every pin input.
  pflc_bus_t bus_meta;
  pflc_bus_t bus_sync;
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bus_meta <= '0;
      bus_sync <= '0;
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      bus_meta <= '{cs: ~chip_sel_n, rd: ~read_n, wr: ~write_n,
                    addr: addr, data: data_in};
      bus_sync <= bus_meta;
      pin_meta <= {~power_fail_in_n, gate_in_zero, gate_in_one,
                   timer_clock_in};
      pin_sync <= pin_meta;
    end
  end

  logic pf_raw;
  assign pf_raw = pin_sync[3];

  // Power-fail debounce in both directions.
  logic pf_failing;
  logic pf_failing_q;
  logic pf_detect;

  pflc_debounce u_pf_debounce (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .tick      (tick),
    .enable    (~standby), // R19
    .level_in  (pf_raw),   // R1 R9
    .level_out (pf_failing)
  );

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pf_failing_q <= 1'b0;
    end else begin
      pf_failing_q <= pf_failing;
    end
  end

  assign pf_detect = pf_failing & ~pf_failing_q; // R2

  // Control registers.
  logic rsel;
  logic pf_route;
  logic delay_en;
  logic pf_int_en;
  logic tse;
  logic tmr_pf_run;
  logic int_pf_run;
  logic single_supply;
  logic osc_fail;
  logic low_bat;
  logic irq_status;

  logic       wr_q;
  logic       wr_commit;
  logic       bus_open;
  pflc_lock_t lock_state;

  assign bus_open  = (lock_state != PFLC_LOCKED) && !standby;
  assign wr_commit = bus_sync.cs && wr_q && !bus_sync.wr && bus_open;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wr_q <= 1'b0;
    end else begin
      wr_q <= bus_sync.wr;
    end
  end

  logic [`PFLC_DATA_W-1:0] wdata;
  logic [`PFLC_ADDR_W-1:0] waddr;
  assign wdata = bus_sync.data;
  assign waddr = bus_sync.addr;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rsel          <= 1'b0;
      pf_route      <= 1'b0;
      delay_en      <= 1'b0;
      pf_int_en     <= 1'b0;
      tmr_pf_run    <= 1'b0;
      int_pf_run    <= 1'b0;
      single_supply <= 1'b0;
      clock_start   <= 1'b0; // R13
    end else if (wr_commit) begin
      if (waddr == `PFLC_OFS_MAIN_STATUS) begin
        rsel <= wdata[`PFLC_MSR_RSEL_BIT];
      end
      if (!rsel && waddr == `PFLC_OFS_ROUTING) begin
        pf_route <= wdata[`PFLC_RTE_ROUTE_BIT]; // R22
        delay_en <= wdata[`PFLC_RTE_DELAY_BIT]; // R5
      end
      if (!rsel && waddr == `PFLC_OFS_PERIODIC) begin
        single_supply <= wdata[`PFLC_PFR_OSC_BIT]; // R15 R20
      end
      if (rsel && waddr == `PFLC_OFS_INT_CTRL1) begin
        pf_int_en <= wdata[`PFLC_IC1_PFIE_BIT];
      end
      if (rsel && waddr == `PFLC_OFS_RT_MODE) begin
        clock_start <= wdata[`PFLC_RTM_START_BIT];
        tmr_pf_run  <= wdata[`PFLC_RTM_TMR_PF_BIT];
        int_pf_run  <= wdata[`PFLC_RTM_INT_PF_BIT];
      end
    end
  end

  // Only the clock start clears the flag; the periodic register write
  // never reaches it, so battery-mode selection leaves it intact.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      osc_fail <= 1'b1; // R13
    end else if (wr_commit && rsel && waddr == `PFLC_OFS_RT_MODE &&
                 wdata[`PFLC_RTM_START_BIT]) begin
      osc_fail <= 1'b0; // R14 R15
    end
  end

  // Low-battery sampling is frozen with the interrupt enable low.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      low_bat <= 1'b0;
    end else if (pf_int_en && !standby) begin // R11
      low_bat <= battery_low; // R12
    end
  end

  // Time save: the standby edge wins over a same-cycle software set,
  // since the copy must freeze at the switch to battery.
  logic standby_q;
  logic tse_wr;
  assign tse_wr = wr_commit && rsel && waddr == `PFLC_OFS_INT_CTRL0;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      standby_q <= 1'b0;
      tse       <= 1'b0;
    end else begin
      standby_q <= standby; // R18
      if (standby && !standby_q) begin
        tse <= 1'b0; // R17
      end else if (tse_wr) begin
        tse <= wdata[`PFLC_IC0_TSE_BIT]; // R17
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      saved_time <= '0;
    end else if (tse) begin
      saved_time <= clock_count; // R16
    end
  end

  // Strobe watchdog: armed when failure lands during a selected access.
  logic strobe_armed;
  logic strobe_done;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      strobe_armed <= 1'b0;
    end else if (!pf_failing || !(bus_sync.rd || bus_sync.wr)) begin
      strobe_armed <= 1'b0;
    end else if (pf_detect && bus_sync.cs) begin
      strobe_armed <= 1'b1; // R6
    end
  end

  pflc_interval #(.LIMIT(`PFLC_STROBE_TICKS)) u_strobe_timer (
    .clock   (clock),
    .sys_rst (sys_rst),
    .tick    (tick),
    .run     (strobe_armed),
    .done    (strobe_done)
  );

  // Lock-out state machine.
  logic       delay_done;

  pflc_interval #(.LIMIT(`PFLC_DELAY_TICKS)) u_delay_timer (
    .clock   (clock),
    .sys_rst (sys_rst),
    .tick    (tick),
    .run     (lock_state == PFLC_DELAY),
    .done    (delay_done)
  );

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lock_state <= PFLC_RUN;
    end else begin
      unique case (lock_state)
        PFLC_RUN: begin
          if (pf_failing && delay_en) begin
            lock_state <= PFLC_DELAY; // R4
          end else if (pf_failing) begin
            lock_state <= PFLC_LOCKED; // R3
          end
        end
        PFLC_DELAY: begin
          if (!pf_failing) begin
            lock_state <= PFLC_RUN;
          end else if (!delay_en || delay_done || strobe_done) begin
            lock_state <= PFLC_LOCKED; // R4 R5 R6
          end
        end
        PFLC_LOCKED: begin
          if (!pf_failing) begin
            lock_state <= PFLC_RUN; // R9
          end
        end
        default: begin
          lock_state <= PFLC_LOCKED;
        end
      endcase
    end
  end

  // Interrupt: level while failing and enabled; cannot be cleared.
  logic pf_irq;
  logic irq_level;
  logic mfo_level;

  assign pf_irq    = pf_failing && pf_int_en; // R2 R10
  assign irq_level = pf_irq && !pf_route; // R22
  assign mfo_level = (pf_irq && pf_route) || multifunction_level; // R22

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      irq_status <= 1'b0;
    end else begin
      irq_status <= pf_irq;
    end
  end

  // Register read path.
  logic [`PFLC_DATA_W-1:0] next_rd_data;

  always_comb begin
    next_rd_data = `PFLC_DATA_ZERO;
    if (bus_sync.addr == `PFLC_OFS_MAIN_STATUS) begin
      next_rd_data[`PFLC_MSR_IRQ_BIT]    = irq_status;
      next_rd_data[`PFLC_MSR_PF_BIT]     = pf_failing; // R21
      next_rd_data[`PFLC_MSR_LOWBAT_BIT] = low_bat;
      next_rd_data[`PFLC_MSR_RSEL_BIT]   = rsel;
    end else if (!rsel && bus_sync.addr == `PFLC_OFS_ROUTING) begin
      next_rd_data[`PFLC_RTE_ROUTE_BIT] = pf_route;
      next_rd_data[`PFLC_RTE_DELAY_BIT] = delay_en;
    end else if (!rsel && bus_sync.addr == `PFLC_OFS_PERIODIC) begin
      next_rd_data[`PFLC_PFR_OSC_BIT] = osc_fail;
    end else if (rsel && bus_sync.addr == `PFLC_OFS_INT_CTRL1) begin
      next_rd_data[`PFLC_IC1_PFIE_BIT] = pf_int_en;
    end else if (rsel && bus_sync.addr == `PFLC_OFS_INT_CTRL0) begin
      next_rd_data[`PFLC_IC0_TSE_BIT] = tse;
    end else if (rsel && bus_sync.addr == `PFLC_OFS_RT_MODE) begin
      next_rd_data[`PFLC_RTM_START_BIT]  = clock_start;
      next_rd_data[`PFLC_RTM_TMR_PF_BIT] = tmr_pf_run;
      next_rd_data[`PFLC_RTM_INT_PF_BIT] = int_pf_run;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      data_out <= `PFLC_DATA_ZERO;
      data_oe  <= 1'b0;
    end else begin
      data_out <= next_rd_data;
      data_oe  <= bus_sync.cs && bus_sync.rd && bus_open; // R7
    end
  end

  // Pin isolation and run permissions.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      gate_zero_live    <= 1'b0;
      gate_one_live     <= 1'b0;
      timer_clock_live  <= 1'b0;
      irq_out           <= '0;
      multifunction_out <= '0;
      timer_one_out     <= '0;
      timers_run        <= 1'b1;
      interrupts_run    <= 1'b1;
      bus_locked        <= 1'b0;
    end else begin
      gate_zero_live   <= pin_sync[2] && !standby; // R7
      gate_one_live    <= pin_sync[1] && !standby; // R7
      timer_clock_live <= pin_sync[0] && !standby; // R7
      // In standby the pins only ever pull low, as open drain.
      if (standby) begin
        irq_out           <= '{value: 1'b0, oe: ~irq_level}; // R7
        multifunction_out <= '{value: 1'b0, oe: ~mfo_level}; // R7
        timer_one_out     <= '{value: 1'b0, oe: ~timer_one_level}; // R7
      end else begin
        irq_out           <= '{value: irq_level, oe: 1'b1};
        multifunction_out <= '{value: mfo_level, oe: 1'b1};
        timer_one_out     <= '{value: timer_one_level, oe: 1'b1};
      end
      timers_run     <= !pf_failing || tmr_pf_run; // R8
      interrupts_run <= !pf_failing || int_pf_run; // R8
      bus_locked     <= !bus_open; // R7
    end
  end

endmodule
`default_nettype wire

// ### pflc_monitor.sv
// Purpose: Port-level checks of the power-fail lock-out block.
// Assumes: One clock domain; async active-high reset.
// Notes:   Bound to pflc_top after the module.
`timescale 1ns/1ps
`default_nettype none
`include "pflc_params.svh"
module pflc_monitor (
  // Clock and reset
  input wire logic                    clock,
  input wire logic                    sys_rst,
  // Inputs watched
  input wire logic                    chip_sel_n,
  input wire logic                    read_n,
  input wire logic                    power_fail_in_n,
  input wire logic                    standby,
  input wire logic                    timer_one_level,
  // Outputs watched
  input wire logic                    data_oe,
  input wire logic                    gate_zero_live,
  input wire logic                    gate_one_live,
  input wire logic                    timer_clock_live,
  input wire pflc_pkg::pflc_pin_t     irq_out,
  input wire pflc_pkg::pflc_pin_t     multifunction_out,
  input wire pflc_pkg::pflc_pin_t     timer_one_out,
  input wire logic [`PFLC_SAVE_W-1:0] saved_time,
  input wire logic                    bus_locked
);
  import pflc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_standby_settled; standby [*3]; endsequence
  sequence s_main_settled; (!standby) [*3]; endsequence
  sequence s_read_held;
    (!chip_sel_n && !read_n && !bus_locked && !standby) [*5];
  endsequence

  // The pin must have been low 40 cycles before any lock outside standby.
  property p_lock_cause;
    $rose(bus_locked) && !standby |-> !$past(power_fail_in_n, 40);
  endproperty
  a_lock_cause: assert property (p_lock_cause)
    else $error("lock without held fail input");
  property p_unlock_cause;
    $fell(bus_locked) && !$past(standby, 3) |-> $past(power_fail_in_n, 40);
  endproperty
  a_unlock_cause: assert property (p_unlock_cause)
    else $error("unlock with fail input low");
  property p_irq_cause;
    $rose(irq_out.value) |-> !$past(power_fail_in_n, 40);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("irq without held fail input");
  property p_locked_quiet; bus_locked && $past(bus_locked, 3) |-> !data_oe;
  endproperty
  a_locked_quiet: assert property (p_locked_quiet)
    else $error("data driven while locked");
  property p_read_answer;
    s_read_held |-> data_oe or (##[1:2] bus_locked);
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("held read not answered");
  property p_standby_locks; $rose(standby) |-> ##[1:3] bus_locked;
  endproperty
  a_standby_locks: assert property (p_standby_locks)
    else $error("standby did not lock");
  property p_gates_off;
    s_standby_settled |->
      !gate_zero_live && !gate_one_live && !timer_clock_live;
  endproperty
  a_gates_off: assert property (p_gates_off)
    else $error("input live in standby");
  property p_open_drain;
    s_standby_settled |-> !irq_out.value && !multifunction_out.value &&
      timer_one_out.oe == !$past(timer_one_level);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("pins not open drain");
  property p_push_pull;
    s_main_settled |-> timer_one_out.oe &&
      timer_one_out.value == $past(timer_one_level);
  endproperty
  a_push_pull: assert property (p_push_pull)
    else $error("timer pin not driven");
  property p_save_frozen;
    standby && $past(standby, 2) |-> $stable(saved_time);
  endproperty
  a_save_frozen: assert property (p_save_frozen)
    else $error("saved time moved");
endmodule

bind pflc_top pflc_monitor pflc_monitor_i (.*);
`default_nettype wire

// ### pflc_host_model.sv
// Purpose: Host processor on the parallel register bus.
// Assumes: Strobes move at the falling edge only.
// Notes:   A refused read returns ok low after eight edges.
`timescale 1ns/1ps
`default_nettype none
`include "pflc_params.svh"
module pflc_host_model (
  // Clock
  input  wire logic                    clock,
  // Bus
  output logic                         chip_sel_n,
  output logic                         read_n,
  output logic                         write_n,
  output logic [`PFLC_ADDR_W-1:0]      addr,
  output logic [`PFLC_DATA_W-1:0]      data_in,
  input  wire logic [`PFLC_DATA_W-1:0] data_out,
  input  wire logic                    data_oe
);
  initial begin
    {chip_sel_n, read_n, write_n} = 3'b111;
    {addr, data_in} = '0;
  end

  // Chip select outlives the strobe so the synced commit still sees it.
  task automatic write_reg(input logic [`PFLC_ADDR_W-1:0] a,
                           input logic [`PFLC_DATA_W-1:0] d);
    @(negedge clock);
    addr = a;
    data_in = d;
    chip_sel_n = 1'b0;
    write_n = 1'b0;
    repeat (4) @(negedge clock);
    write_n = 1'b1;
    repeat (4) @(negedge clock);
    chip_sel_n = 1'b1;
    data_in = ~d;
    repeat (4) @(negedge clock);
  endtask

  task automatic read_reg(input logic [`PFLC_ADDR_W-1:0] a,
                          output logic [`PFLC_DATA_W-1:0] d,
                          output logic ok);
    int n;
    @(negedge clock);
    addr = a;
    chip_sel_n = 1'b0;
    read_n = 1'b0;
    n = 0;
    ok = 1'b0;
    while (!ok && n < 8) begin
      @(negedge clock);
      ok = (data_oe === 1'b1);
      d = data_out;
      n++;
    end
    @(negedge clock);
    read_n = 1'b1;
    chip_sel_n = 1'b1;
    repeat (4) @(negedge clock);
  endtask
endmodule
`default_nettype wire

// ### tb.sv
// Purpose: Self-checking bench for the power-fail lock-out block.
// Assumes: 40 MHz clock; inputs change at the falling edge.
// Notes:   Intervals run at full length; the run stays short.
`timescale 1ns/1ps
`default_nettype none
`include "pflc_params.svh"
module tb;
  import pflc_pkg::*;
  logic                    clock, sys_rst, chip_sel_n, read_n, write_n;
  logic [`PFLC_ADDR_W-1:0] addr;
  logic [`PFLC_DATA_W-1:0] data_in, data_out, rd_data;
  logic                    data_oe, rd_ok, power_fail_in_n, standby;
  logic                    battery_low, gates, timer_one_level;
  logic                    multifunction_level, gate_zero_live;
  logic                    gate_one_live, timer_clock_live, timers_run;
  logic                    interrupts_run, clock_start, bus_locked;
  pflc_pin_t               irq_out, multifunction_out, timer_one_out;
  logic [`PFLC_SAVE_W-1:0] clock_count, saved_time;
  int                      errors, samples_checked;

  pflc_top pflc_top_i (.*, .gate_in_zero(gates), .gate_in_one(gates),
    .timer_clock_in(gates));
  pflc_host_model pflc_host_model_i (.*);

  task automatic end_sim;
    if (errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    pflc_host_model_i.write_reg(a, d);
  endtask
  task automatic rd(input logic [4:0] a);
    pflc_host_model_i.read_reg(a, rd_data, rd_ok);
  endtask
  // Bounded wait for the lock level; a hang ends the run.
  task automatic wait_lock(input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while (bus_locked !== v && n < hi) begin
      @(negedge clock);
      n++;
    end
    chk("lock_time", 1'b1, n >= lo && bus_locked === v);
    if (bus_locked !== v) end_sim();
  endtask

  task automatic t_reset;
    chk("reset_out", 2'b00, {bus_locked, clock_start});
    rd(5'h03);
    chk("osc_flag", 2'b11, {rd_ok, rd_data[6]});
    wr(5'h03, 8'h00);
    rd(5'h03);
    chk("osc_kept", 2'b11, {rd_ok, rd_data[6]});
    wr(5'h00, 8'h80);
    wr(5'h01, 8'h08);
    chk("start", 1'b1, clock_start);
    wr(5'h00, 8'h00);
    rd(5'h03);
    chk("osc_clear", 2'b10, {rd_ok, rd_data[6]});
    rd(5'h1f);
    chk("unmapped", 9'h100, {rd_ok, rd_data});
  endtask
  task automatic t_glitch;
    power_fail_in_n = 1'b0;
    repeat (1000) @(negedge clock);
    power_fail_in_n = 1'b1;
    repeat (200) @(negedge clock);
    chk("glitch", 2'b00, {bus_locked, irq_out.value});
  endtask
  task automatic t_fail(input logic en);
    wr(5'h00, 8'h80);
    wr(5'h04, {en, 7'h00});
    wr(5'h01, 8'h40);
    wr(5'h00, 8'h00);
    wr(5'h04, 8'h00);
    wr(5'h03, {1'b0, ~en, 6'h00});
    power_fail_in_n = 1'b0;
    wait_lock(1'b1, 1200, 2520);
    chk("irq", en, irq_out.value);
    chk("run_bits", 2'b10, {timers_run, interrupts_run});
    rd(5'h00);
    chk("locked_read", 1'b0, rd_ok);
    power_fail_in_n = 1'b1;
    wait_lock(1'b0, 1200, 2520);
    rd(5'h00);
    chk("status", {1'b0, en, 6'h00}, rd_data & 8'h42);
  endtask
  task automatic t_delay;
    wr(5'h04, 8'h09);
    power_fail_in_n = 1'b0;
    repeat (4000) @(negedge clock);
    chk("open", 1'b0, bus_locked);
    chk("route", 2'b01, {irq_out.value, multifunction_out.value});
    rd(5'h04);
    chk("late_read", 9'h109, {rd_ok, rd_data & 8'h09});
    wr(5'h04, 8'h00);
    wait_lock(1'b1, 0, 8);
    power_fail_in_n = 1'b1;
    wait_lock(1'b0, 1200, 2520);
    wr(5'h04, 8'h08);
    power_fail_in_n = 1'b0;
    wait_lock(1'b1, 20000, 20800);
    power_fail_in_n = 1'b1;
    wait_lock(1'b0, 1200, 2520);
  endtask
  task automatic t_standby;
    wr(5'h00, 8'h80);
    wr(5'h03, 8'h80);
    clock_count = 32'h1234_5678;
    repeat (4) @(negedge clock);
    chk("save", 32'h1234_5678, saved_time);
    multifunction_level = 1'b1;
    standby = 1'b1;
    repeat (4) @(negedge clock);
    clock_count = 32'h0000_0abc;
    repeat (4) @(negedge clock);
    chk("frozen", 32'h1234_5678, saved_time);
    chk("sb_lock", 2'b10, {bus_locked, gate_zero_live});
    chk("mfo_od", 2'b00, multifunction_out);
    chk("t1_od", 2'b01, timer_one_out);
    standby = 1'b0;
    repeat (4) @(negedge clock);
    chk("gate_live", 1'b1, gate_zero_live);
    rd(5'h03);
    chk("tse", 9'h100, {rd_ok, rd_data & 8'h80});
  endtask

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    errors = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    power_fail_in_n = 1'b1;
    standby = 1'b0;
    battery_low = 1'b1;
    gates = 1'b1;
    timer_one_level = 1'b0;
    multifunction_level = 1'b0;
    clock_count = 32'h0000_0000;
    repeat (4) @(negedge clock);
    sys_rst = 1'b0;
    @(negedge clock);
    t_reset();
    t_glitch();
    t_fail(1'b0);
    t_fail(1'b1);
    t_delay();
    t_standby();
    end_sim();
  end
endmodule
`default_nettype wire
